// *** rtl/ptc_defines.svh ***
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses (one aligned word each, data in bits 7..0)
// ----------------------------------------------------------------------
`define PTC_ADDR_CTRL0      6'h00
`define PTC_ADDR_CTRL1      6'h04
`define PTC_ADDR_CNT_LOW    6'h08
`define PTC_ADDR_CNT_HIGH   6'h0C
`define PTC_ADDR_CMPA_LOW   6'h10
`define PTC_ADDR_CMPA_HIGH  6'h14
`define PTC_ADDR_PER_LOW    6'h18
`define PTC_ADDR_PER_HIGH   6'h1C
`define PTC_ADDR_STATUS     6'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PTC_C0_PAUSE        7
`define PTC_C0_ON           3
`define PTC_ST_FLAG_A       0
`define PTC_ST_FLAG_P       1

// ----------------------------------------------------------------------
// reset values, limits and the falling-edge clock select code
// ----------------------------------------------------------------------
`define PTC_CMPA_RST        10'h000
`define PTC_PERIOD_RST      10'h000
`define PTC_CNT_MAX         10'h3FF
`define PTC_CKSEL_FALL      3'h7
`endif

// *** rtl/ptc_periodic_timer.sv ***
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ptc_defines.svh"

module ptc_periodic_timer
  import ptc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        timer_tick,
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_used,
  output logic             match_a_flag,
  output logic             match_p_flag
);

  ptc_state_t  st;
  ptc_state_t  next_st;
  logic [10:0] inc;
  logic        run;
  logic        single;
  logic        a_hit;
  logic        p_hit;
  logic        set_a;
  logic        set_p;
  logic        clr;
  logic        rise_on;
  logic        ext_edge;
  logic        pwm_act;
  logic        wr_go;
  logic [7:0]  wd;
  logic [31:0] rd;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st  = st;
    wd       = writedata[7:0];
    inc      = {1'b0, st.count} + 11'h001;
    run      = st.on && !st.pause && timer_tick;
    single   = (st.mode == PTC_MODE_PWM) && (st.pin_act == PTC_ACT_A11);
    a_hit    = (inc[9:0] == st.cmpa) && (st.cmpa != 10'h000);
    // zero period means the natural 3FF -> 0 wrap
    p_hit    = (st.period != 10'h000) ? (inc[9:0] == st.period) : inc[10];
    set_a    = 1'b0;
    set_p    = 1'b0;
    clr      = 1'b0;
    rise_on  = st.on && !st.on_prev;
    wr_go    = write && !st.waitreq && byteenable[0];
    pwm_act  = 1'b0;
    rd       = 32'h0000_0000;

    // counter clear and match flags per mode
    case (st.mode)
      PTC_MODE_CMP, PTC_MODE_TMR:
      begin
        if (st.clr_src)
        begin
          set_a = a_hit;
          clr   = a_hit;
        end
        else
        begin
          set_a = a_hit;
          set_p = p_hit;
          clr   = p_hit;
        end
      end
      PTC_MODE_PWM:
      begin
        if (single)
        begin
          set_a = a_hit;
        end
        else
        begin
          set_a = a_hit;
          set_p = p_hit;
          clr   = p_hit;
        end
      end
      default:
      begin
        // capture latching is not built; the counter still wraps on period
        set_p = p_hit;
        clr   = p_hit;
      end
    endcase
    set_a = set_a && run;
    set_p = set_p && run;

    // counter
    if (rise_on)
    begin
      next_st.count    = 10'h000;
      next_st.cm_level = st.init_lvl;
    end
    else if (run)
    begin
      next_st.count = clr ? 10'h000 : inc[9:0];
    end
    next_st.on_prev = st.on;

    // compare mode pin action on A match only
    if ((st.mode == PTC_MODE_CMP) && set_a && !rise_on)
    begin
      case (st.pin_act)
        PTC_ACT_A01: next_st.cm_level = 1'b0;
        PTC_ACT_A10: next_st.cm_level = 1'b1;
        PTC_ACT_A11: next_st.cm_level = ~st.cm_level;
        default:     next_st.cm_level = st.cm_level;
      endcase
    end

    // single pulse: A match ends the pulse by dropping counter-on
    if (single && set_a)
    begin
      next_st.on = 1'b0;
    end

    // external pin: two-flop sync, then edge for auto start
    next_st.ext_s1   = external_clock_pin;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    ext_edge = (st.clk_sel == `PTC_CKSEL_FALL) ? (!st.ext_s2 && st.ext_prev)
                                               : (st.ext_s2 && !st.ext_prev);
    if (single && !st.on && ext_edge)
    begin
      next_st.on = 1'b1;
    end

    // output pin
    case (st.mode)
      PTC_MODE_CMP:
      begin
        next_st.pin      = st.cm_level ^ st.invert;
        next_st.pin_used = 1'b1;
      end
      PTC_MODE_PWM:
      begin
        if (single)
        begin
          pwm_act = st.on;
        end
        else
        begin
          case (st.pin_act)
            PTC_ACT_A00: pwm_act = 1'b0;
            PTC_ACT_A01: pwm_act = 1'b1;
            default:     pwm_act = (st.count < st.cmpa) ||
                                   ((st.period != 10'h000) && (st.cmpa >= st.period));
          endcase
        end
        next_st.pin      = (pwm_act ? st.init_lvl : ~st.init_lvl) ^ st.invert;
        next_st.pin_used = 1'b1;
      end
      default:
      begin
        next_st.pin      = 1'b0;
        next_st.pin_used = 1'b0;
      end
    endcase

    // read mux
    case (address)
      `PTC_ADDR_CTRL0:     rd = {24'h00_0000, st.pause, st.clk_sel, st.on, 3'b000};
      `PTC_ADDR_CTRL1:     rd = {24'h00_0000, st.mode, st.pin_act, st.init_lvl, st.invert,
                                 st.cap_src, st.clr_src};
      `PTC_ADDR_CNT_LOW:   rd = {24'h00_0000, st.count[7:0]};
      `PTC_ADDR_CNT_HIGH:  rd = {30'h0000_0000, st.count[9:8]};
      `PTC_ADDR_CMPA_LOW:  rd = {24'h00_0000, st.cmpa[7:0]};
      `PTC_ADDR_CMPA_HIGH: rd = {30'h0000_0000, st.cmpa[9:8]};
      `PTC_ADDR_PER_LOW:   rd = {24'h00_0000, st.period[7:0]};
      `PTC_ADDR_PER_HIGH:  rd = {30'h0000_0000, st.period[9:8]};
      `PTC_ADDR_STATUS:    rd = {30'h0000_0000, st.flag_p, st.flag_a};
      default:             rd = 32'h0000_0000;
    endcase

    // bus: one idle-to-answer cycle, then waitrequest drops for one cycle
    if ((read || write) && st.waitreq)
    begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = read ? rd : 32'h0000_0000;
    end
    else
    begin
      next_st.waitreq = 1'b1;
    end

    // flags: set wins over a write-one clear in the same cycle
    next_st.flag_a = st.flag_a | set_a;
    next_st.flag_p = st.flag_p | set_p;

    // register writes land at the edge where waitrequest is seen low
    if (wr_go)
    begin
      case (address)
        `PTC_ADDR_CTRL0:
        begin
          next_st.pause   = wd[`PTC_C0_PAUSE];
          next_st.clk_sel = wd[6:4];
          next_st.on      = wd[`PTC_C0_ON];
        end
        `PTC_ADDR_CTRL1:
        begin
          next_st.mode     = ptc_mode_t'(wd[7:6]);
          next_st.pin_act  = ptc_pin_act_t'(wd[5:4]);
          next_st.init_lvl = wd[3];
          next_st.invert   = wd[2];
          next_st.cap_src  = wd[1];
          next_st.clr_src  = wd[0];
        end
        `PTC_ADDR_CMPA_LOW:  next_st.cmpa[7:0]   = wd;
        `PTC_ADDR_CMPA_HIGH: next_st.cmpa[9:8]   = wd[1:0];
        `PTC_ADDR_PER_LOW:   next_st.period[7:0] = wd;
        `PTC_ADDR_PER_HIGH:  next_st.period[9:8] = wd[1:0];
        `PTC_ADDR_STATUS:
        begin
          next_st.flag_a = (st.flag_a & ~wd[`PTC_ST_FLAG_A]) | set_a;
          next_st.flag_p = (st.flag_p & ~wd[`PTC_ST_FLAG_P]) | set_p;
        end
        default:
        begin
          next_st.flag_a = st.flag_a | set_a;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st         <= '0;
      st.cmpa    <= `PTC_CMPA_RST;
      st.period  <= `PTC_PERIOD_RST;
      st.waitreq <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign readdata          = st.rdata;
  assign waitrequest       = st.waitreq;
  assign timer_output_pin  = st.pin;
  assign timer_output_used = st.pin_used;
  assign match_a_flag      = st.flag_a;
  assign match_p_flag      = st.flag_p;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_CNT_HIGH_ZERO:
  assert property ((read && st.waitreq && address == `PTC_ADDR_CNT_HIGH) |=>
                   (!waitrequest && readdata == {30'h0000_0000, $past(st.count[9:8])}))
    else $error("counter high byte read back wrong");

  AST_CMPA_HIGH_BACK:
  assert property ((wr_go && address == `PTC_ADDR_CMPA_HIGH) |=>
                   (st.cmpa[9:8] == $past(writedata[1:0])))
    else $error("compare A high bits not stored");

  AST_PER_HIGH_READ:
  assert property ((read && st.waitreq && address == `PTC_ADDR_PER_HIGH) |=>
                   (readdata[31:2] == 30'h0000_0000 && readdata[1:0] == st.period[9:8]))
    else $error("period high byte read back wrong");

  AST_P_CLEAR:
  assert property ((st.mode == PTC_MODE_CMP && !st.clr_src && run && !rise_on &&
                    st.period != 10'h000 && inc[9:0] == st.period && !wr_go) |=>
                   (st.count == 10'h000 && match_p_flag))
    else $error("period match did not clear counter and set P flag");

  AST_NO_P_FLAG:
  assert property ((st.mode == PTC_MODE_CMP && st.clr_src && !st.flag_p) |=> !match_p_flag)
    else $error("P flag raised with clear source A");

  AST_A_ZERO_WRAP:
  assert property (((st.mode == PTC_MODE_CMP) || (st.mode == PTC_MODE_TMR)) &&
                   st.cmpa == 10'h000 && run && !rise_on &&
                   st.count == `PTC_CNT_MAX && !st.flag_a && !wr_go |=>
                   (st.count == 10'h000 && !match_a_flag))
    else $error("zero compare A did not wrap quietly");

  AST_ON_RISE:
  assert property ((rise_on && !wr_go) |=>
                   (st.count == 10'h000 && st.cm_level == $past(st.init_lvl)) ##1
                   (st.mode != PTC_MODE_CMP || timer_output_pin == (st.cm_level ^ st.invert)))
    else $error("counter-on rise did not zero counter");

  AST_PWM_FULL:
  assert property ((st.mode == PTC_MODE_PWM && st.pin_act == PTC_ACT_A10 && !st.invert &&
                    st.period != 10'h000 && st.cmpa >= st.period) |=>
                   (timer_output_pin == $past(st.init_lvl)))
    else $error("pwm not at full duty");

  AST_SP_END:
  assert property ((single && run && a_hit && !wr_go) |=> (!st.on && match_a_flag) ##1
                   (timer_output_pin == (~st.init_lvl ^ st.invert)))
    else $error("single pulse not ended by A match");

  AST_TC_PIN:
  assert property ((st.mode == PTC_MODE_TMR) |=> (!timer_output_used && !timer_output_pin))
    else $error("pin used in timer mode");

endmodule

// *** rtl/ptc_pkg.sv ***
package ptc_pkg;

  typedef enum logic [1:0]
  {
    PTC_MODE_CMP  = 2'b00,
    PTC_MODE_CAP  = 2'b01,
    PTC_MODE_PWM  = 2'b10,
    PTC_MODE_TMR  = 2'b11
  } ptc_mode_t;

  typedef enum logic [1:0]
  {
    PTC_ACT_A00 = 2'b00,
    PTC_ACT_A01 = 2'b01,
    PTC_ACT_A10 = 2'b10,
    PTC_ACT_A11 = 2'b11
  } ptc_pin_act_t;

  typedef struct packed
  {
    logic         pause;
    logic [2:0]   clk_sel;
    logic         on;
    logic         on_prev;
    ptc_mode_t    mode;
    ptc_pin_act_t pin_act;
    logic         init_lvl;
    logic         invert;
    logic         cap_src;
    logic         clr_src;
    logic [9:0]   cmpa;
    logic [9:0]   period;
    logic [9:0]   count;
    logic         flag_a;
    logic         flag_p;
    logic         cm_level;
    logic         ext_s1;
    logic         ext_s2;
    logic         ext_prev;
    logic         pin;
    logic         pin_used;
    logic         waitreq;
    logic [31:0]  rdata;
  } ptc_state_t;

endpackage

// *** testbench/ptc_periodic_timer_tb.sv ***
`timescale 1ns/1ps
`include "ptc_defines.svh"

module ptc_periodic_timer_tb
  import ptc_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0]  byteenable = 4'hF;
  logic        timer_tick = 1'b0;
  logic        external_clock_pin = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        timer_output_pin;
  logic        timer_output_used;
  logic        match_a_flag;
  logic        match_p_flag;
  logic [7:0]  rd;
  logic [7:0]  hi;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;

  ptc_periodic_timer u_dut (
    .clk                (clk),
    .nrst               (nrst),
    .address            (address),
    .read               (read),
    .write              (write),
    .writedata          (writedata),
    .byteenable         (byteenable),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .timer_tick         (timer_tick),
    .external_clock_pin (external_clock_pin),
    .timer_output_pin   (timer_output_pin),
    .timer_output_used  (timer_output_used),
    .match_a_flag       (match_a_flag),
    .match_p_flag       (match_p_flag)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task results;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // whole run needs under two thousand cycles; a stuck handshake ends here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results;
    end
  end

  task cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task cmp1(input string n, input logic e, input logic s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask

  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  // request held until the edge that samples waitrequest low
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    read      <= ~w;
    write     <= w;
    writedata <= {24'h00_0000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task rdc(input string n, input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp8(n, e, rd);
  endtask

  // n back-to-back ticks, then settle so the one-edge pin lag has landed
  task ticks(input int n);
    @(posedge clk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge clk);
    timer_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // restart, skip one period, then count high samples over two periods of 4
  task pwm(input logic [7:0] c1, input logic [7:0] ca, input logic [7:0] e);
    wr(`PTC_ADDR_CTRL0, 8'h00);
    wr(`PTC_ADDR_CTRL1, c1);
    wr(`PTC_ADDR_CMPA_LOW, ca);
    wr(`PTC_ADDR_CTRL0, 8'h08);
    @(posedge clk);
    timer_tick <= 1'b1;
    repeat (4) @(posedge clk);
    hi = 8'h00;
    repeat (8)
    begin
      @(posedge clk);
      hi = hi + {7'h00, timer_output_pin};
    end
    timer_tick <= 1'b0;
    cmp8("pwm_high_count", e, hi);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc("cmpa_low", `PTC_ADDR_CMPA_LOW, 8'h00);
    rdc("cmpa_high", `PTC_ADDR_CMPA_HIGH, 8'h00);
    rdc("per_low", `PTC_ADDR_PER_LOW, 8'h00);
    rdc("per_high", `PTC_ADDR_PER_HIGH, 8'h00);
    rdc("unmapped", 6'h24, 8'h00);
    // timer mode, zero period and zero compare: free run to overflow
    wr(`PTC_ADDR_CTRL1, 8'hC0);
    wr(`PTC_ADDR_CTRL0, 8'h08);
    ticks(300);
    rdc("cnt_low", `PTC_ADDR_CNT_LOW, 8'h2C);
    rdc("cnt_high", `PTC_ADDR_CNT_HIGH, 8'h01);
    wr(`PTC_ADDR_CNT_HIGH, 8'hFF);
    rdc("cnt_high_ro", `PTC_ADDR_CNT_HIGH, 8'h01);
    cmp1("pin_used", 1'b0, timer_output_used);
    ticks(724);
    rdc("cnt_wrap", `PTC_ADDR_CNT_HIGH, 8'h00);
    cmp1("flag_a", 1'b0, match_a_flag);
    cmp1("flag_p", 1'b1, match_p_flag);
    wr(`PTC_ADDR_CMPA_HIGH, 8'hFF);
    rdc("cmpa_high_w", `PTC_ADDR_CMPA_HIGH, 8'h03);
    wr(`PTC_ADDR_PER_HIGH, 8'hFE);
    rdc("per_high_w", `PTC_ADDR_PER_HIGH, 8'h02);
    wr(`PTC_ADDR_CMPA_HIGH, 8'h00);
    wr(`PTC_ADDR_PER_HIGH, 8'h00);
    // compare mode: every pin action against both initial levels
    wr(`PTC_ADDR_PER_LOW, 8'h05);
    wr(`PTC_ADDR_CMPA_LOW, 8'h03);
    for (int j = 0; j < 8; j++)
    begin
      wr(`PTC_ADDR_CTRL0, 8'h00);
      wr(`PTC_ADDR_CTRL1, {2'b00, j[1:0], j[2], 3'b000});
      wr(`PTC_ADDR_CTRL0, 8'h08);
      // the pin follows the restart two edges after the write lands
      repeat (3) @(posedge clk);
      cmp1("pin_init", j[2], timer_output_pin);
      ticks(3);
      cmp1("pin_act", j[2] ? ~j[0] : j[1], timer_output_pin);
    end
    // toggle, stop and hold, restart, then a period clear
    wr(`PTC_ADDR_CTRL0, 8'h00);
    wr(`PTC_ADDR_STATUS, 8'h03);
    @(posedge clk);
    cmp1("flag_a_clr", 1'b0, match_a_flag);
    cmp1("pin_used_cmp", 1'b1, timer_output_used);
    ticks(2);
    rdc("cnt_hold", `PTC_ADDR_CNT_LOW, 8'h03);
    wr(`PTC_ADDR_CTRL0, 8'h08);
    rdc("cnt_restart", `PTC_ADDR_CNT_LOW, 8'h00);
    cmp1("pin_restart", 1'b1, timer_output_pin);
    ticks(5);
    cmp1("flag_a", 1'b1, match_a_flag);
    cmp1("flag_p", 1'b1, match_p_flag);
    cmp1("pin_after_p", 1'b0, timer_output_pin);
    rdc("cnt_pclear", `PTC_ADDR_CNT_LOW, 8'h00);
    // compare A clears the counter, period below A stays silent
    wr(`PTC_ADDR_CTRL0, 8'h00);
    wr(`PTC_ADDR_STATUS, 8'h03);
    wr(`PTC_ADDR_PER_LOW, 8'h02);
    wr(`PTC_ADDR_CMPA_LOW, 8'h04);
    wr(`PTC_ADDR_CTRL1, 8'h31);
    wr(`PTC_ADDR_CTRL0, 8'h08);
    ticks(4);
    cmp1("flag_a", 1'b1, match_a_flag);
    cmp1("flag_p", 1'b0, match_p_flag);
    rdc("cnt_aclear", `PTC_ADDR_CNT_LOW, 8'h00);
    // pwm with period 4
    wr(`PTC_ADDR_CTRL0, 8'h00);
    wr(`PTC_ADDR_STATUS, 8'h03);
    wr(`PTC_ADDR_PER_LOW, 8'h04);
    pwm(8'hA8, 8'h01, 8'h02);
    cmp1("pwm_flag_a", 1'b1, match_a_flag);
    cmp1("pwm_flag_p", 1'b1, match_p_flag);
    pwm(8'hA9, 8'h01, 8'h02);
    pwm(8'hA8, 8'h04, 8'h08);
    pwm(8'hA8, 8'h05, 8'h08);
    pwm(8'hAC, 8'h01, 8'h06);
    pwm(8'hA0, 8'h01, 8'h06);
    pwm(8'h88, 8'h01, 8'h00);
    pwm(8'h98, 8'h01, 8'h08);
    // single pulse: software start, compare A end, then pin start
    wr(`PTC_ADDR_CTRL0, 8'h00);
    wr(`PTC_ADDR_STATUS, 8'h03);
    wr(`PTC_ADDR_CMPA_LOW, 8'h03);
    wr(`PTC_ADDR_CTRL1, 8'hB8);
    wr(`PTC_ADDR_CTRL0, 8'h08);
    repeat (2) @(posedge clk);
    cmp1("pulse_lead", 1'b1, timer_output_pin);
    ticks(3);
    rdc("auto_off", `PTC_ADDR_CTRL0, 8'h00);
    cmp1("pulse_trail", 1'b0, timer_output_pin);
    cmp1("pulse_flag_a", 1'b1, match_a_flag);
    @(posedge clk);
    external_clock_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("auto_on", `PTC_ADDR_CTRL0, 8'h08);
    cmp1("pin_lead", 1'b1, timer_output_pin);
    rdc("cnt_zero", `PTC_ADDR_CNT_LOW, 8'h00);
    wr(`PTC_ADDR_CTRL0, 8'h00);
    repeat (3) @(posedge clk);
    cmp1("soft_end", 1'b0, timer_output_pin);
    // capture mode has no output function
    wr(`PTC_ADDR_CTRL1, 8'h40);
    repeat (3) @(posedge clk);
    cmp1("cap_pin_used", 1'b0, timer_output_used);
    results;
  end
endmodule
